// ---- rtl/bcr_pkg.sv ----
// Package with the register map, reset values, field layouts and carrier types of the boost register bank.
package bcr_pkg;

    localparam int NUM_REGS = 21;

    // Storage slots of the writable registers.
    localparam int IDX_GATE_ROUTE  = 0;
    localparam int IDX_OUT1_DIV    = 1;
    localparam int IDX_OUT2_DIV    = 2;
    localparam int IDX_OUT1_PHEN   = 3;
    localparam int IDX_OUT2_PHEN   = 4;
    localparam int IDX_OUT1_PHOFF  = 5;
    localparam int IDX_OUT2_PHOFF  = 6;
    localparam int IDX_GATE_PHASE  = 7;
    localparam int IDX_PHASE_SEL   = 8;
    localparam int IDX_PROP_GAIN   = 9;
    localparam int IDX_INTEG_GAIN  = 10;
    localparam int IDX_SLOPE_COMP  = 11;
    localparam int IDX_SENSE_RES   = 12;
    localparam int IDX_GATE_SUPPLY = 13;
    localparam int IDX_INPUT_HIGH  = 17;
    localparam int IDX_INPUT_LOW   = 18;

    localparam logic [6:0] REG_ADDR [NUM_REGS] = '{
        7'h02, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12,
        7'h13, 7'h14, 7'h15, 7'h19, 7'h25, 7'h26, 7'h1a, 7'h1b, 7'h2f, 7'h30};
    localparam logic [7:0] REG_RESET [NUM_REGS] = '{
        8'h00, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h39, 8'h39, 8'h00, 8'he4, 8'h00, 8'h00,
        8'h88, 8'h00, 8'hff, 8'h82, 8'h27, 8'h3b, 8'hff, 8'h00, 8'he8, 8'h09};
    // Bits that software may change; reserved bits keep their reset value.
    localparam logic [7:0] REG_MASK [NUM_REGS] = '{
        8'h03, 8'hff, 8'hff, 8'h0f, 8'h0f, 8'hff, 8'hff, 8'h03, 8'h0f, 8'hff, 8'hff,
        8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

    // Read-only and diagnostic addresses.
    localparam logic [6:0] ADDR_COUNT_LOW   = 7'h41;
    localparam logic [6:0] ADDR_COUNT_HIGH  = 7'h42;
    localparam logic [6:0] ADDR_SUPPLY_MEAS = 7'h45;
    localparam logic [6:0] ADDR_TEMP_MEAS   = 7'h46;
    localparam logic [6:0] ADDR_HEALTH      = 7'h5f;

    // Control registers that live outside this bank.
    localparam logic [6:0] ADDR_CTRL_LAST = 7'h08;
    localparam logic [6:0] ADDR_FREQ_TRIM = 7'h1c;

    // Health status bit positions.
    localparam int HB_OUT1_GOOD  = 7;
    localparam int HB_OUT2_GOOD  = 6;
    localparam int HB_GATE_GOOD  = 5;
    localparam int HB_OVERTEMP   = 4;
    localparam int HB_UNDERVOLT  = 3;
    localparam int HB_OVERVOLT   = 2;
    localparam int HB_SERIAL_ERR = 1;
    localparam int HB_GATE_ERR   = 0;
    localparam logic [7:0] HEALTH_ERR_MASK = 8'h1f;

    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] data;
    } bcr_req_s;

    typedef struct packed {
        logic       gate1_route;
        logic       gate2_route;
        logic       gate1_phase_route;
        logic       gate2_phase_route;
        logic [7:0] out1_divider;
        logic [7:0] out2_divider;
        logic [3:0] out1_phase_on;
        logic [3:0] out2_phase_on;
        logic [4:0] out1_phase_delay;
        logic [2:0] out1_phase_off;
        logic [4:0] out2_phase_delay;
        logic [2:0] out2_phase_off;
        logic [1:0] out1_phase_select;
        logic [1:0] out2_phase_select;
        logic [3:0] out1_prop_gain;
        logic [3:0] out2_prop_gain;
        logic [3:0] out1_integral_gain;
        logic [3:0] out2_integral_gain;
        logic [3:0] out1_slope_comp;
        logic [3:0] out2_slope_comp;
        logic [1:0] out1_sense_resistor;
        logic [1:0] out2_sense_resistor;
        logic [7:0] gate_supply_level;
        logic [7:0] input_high_limit;
        logic [7:0] input_low_limit;
    } bcr_cfg_s;

    typedef struct packed {
        logic overtemp_error;
        logic input_undervolt_flag;
        logic input_overvolt_flag;
        logic gate_supply_error;
    } bcr_evt_s;

endpackage : bcr_pkg

// ---- rtl/bcr_regs.sv ----
// Configuration, internal and diagnostic register bank of the two-output boost controller.
`timescale 1ns/100ps

module bcr_regs (
    input  wire logic            clk_sys,            // System clock, 200 MHz.
    input  wire logic            sys_rst,            // Synchronous reset, active high.
    input  wire logic            config_done,        // Configuration finished; locks the bank when high.
    input  wire logic            req_valid,          // One-cycle access strobe from the frame logic.
    input  wire bcr_pkg::bcr_req_s req,              // Access: write flag, address, data.
    input  wire logic            frame_len_error,    // Pulse: frame length not a multiple of 16.
    input  wire logic            output1_good,       // Analog level: output 1 within range.
    input  wire logic            output2_good,       // Analog level: output 2 within range.
    input  wire logic            gate_supply_good,   // Analog level: gate supply within range.
    input  wire bcr_pkg::bcr_evt_s events,           // Error event pulses from the monitors.
    input  wire logic [15:0]     select_event_count, // Chip-select event counter.
    input  wire logic [7:0]      supply_meas,        // Supply voltage measurement.
    input  wire logic [7:0]      temp_meas,          // Die temperature measurement.
    output logic                 rsp_valid,          // One cycle after req_valid.
    output logic                 rsp_hit,            // Address belongs to this bank.
    output logic [7:0]           rsp_data,           // Read value, new written value, or zero.
    output logic [7:0]           rsp_status,         // Health status at the answer.
    output bcr_pkg::bcr_cfg_s    cfg                 // Decoded configuration fields.
);

    logic [7:0]  regs [bcr_pkg::NUM_REGS];
    logic [7:0]  health_err;
    logic [1:0]  good1_sync;
    logic [1:0]  good2_sync;
    logic [1:0]  gate_sync;
    logic [7:0]  health_status;
    logic        slot_hit;
    logic [4:0]  slot;
    logic        is_ro;
    logic        is_health;
    logic        is_foreign;
    logic        erratic;
    logic        store;
    logic [7:0]  next_value;
    logic [7:0]  read_value;

    // Decode the address into a storage slot.
    always_comb begin
        slot_hit = 1'b0;
        slot     = 5'h00;
        for (int i = 0; i < bcr_pkg::NUM_REGS; i++) begin
            if (req.addr == bcr_pkg::REG_ADDR[i]) begin
                slot_hit = 1'b1;
                slot     = 5'(i);
            end
        end
    end

    assign is_health  = (req.addr == bcr_pkg::ADDR_HEALTH);
    assign is_ro      = (req.addr == bcr_pkg::ADDR_COUNT_LOW) || (req.addr == bcr_pkg::ADDR_COUNT_HIGH) ||
                        (req.addr == bcr_pkg::ADDR_SUPPLY_MEAS) || (req.addr == bcr_pkg::ADDR_TEMP_MEAS);
    // Control registers are answered elsewhere, so they are neither ours nor reserved.
    assign is_foreign = (req.addr <= bcr_pkg::ADDR_CTRL_LAST && !slot_hit) || (req.addr == bcr_pkg::ADDR_FREQ_TRIM);

    // Locked writes, writes to read-only or reserved space, and reserved reads are erratic.
    always_comb begin
        erratic = 1'b0;
        if (req_valid && !is_foreign) begin
            if (req.write) begin
                erratic = (slot_hit && config_done) || is_ro || !(slot_hit || is_health);
            end else begin
                erratic = !(slot_hit || is_ro || is_health);
            end
        end
    end

    assign store      = req_valid && req.write && slot_hit && !config_done;
    assign next_value = (regs[slot] & ~bcr_pkg::REG_MASK[slot]) | (req.data & bcr_pkg::REG_MASK[slot]);

    // Every writable register, internal ones included, is held at reset and locked once configured.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < bcr_pkg::NUM_REGS; i++) begin
                regs[i] <= bcr_pkg::REG_RESET[i];
            end
        end else if (store) begin
            regs[slot] <= next_value;
        end
    end

    // The good levels come from analog comparators and are synchronised before use.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            good1_sync <= 2'b00;
            good2_sync <= 2'b00;
            gate_sync  <= 2'b00;
        end else begin
            good1_sync <= {good1_sync[0], output1_good};
            good2_sync <= {good2_sync[0], output2_good};
            gate_sync  <= {gate_sync[0], gate_supply_good};
        end
    end

    // Sticky error bits: a write to the status register clears them, a same-cycle event still sets.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            health_err <= 8'h00;
        end else begin
            health_err <= ((req_valid && req.write && is_health) ? 8'h00 : health_err)
                        | {3'b000, events.overtemp_error, events.input_undervolt_flag,
                           events.input_overvolt_flag, erratic || frame_len_error,
                           events.gate_supply_error};
        end
    end

    assign health_status = {good1_sync[1], good2_sync[1], gate_sync[1], health_err[4:0]};

    always_comb begin
        read_value = 8'h00;
        if (slot_hit) begin
            read_value = regs[slot];
        end else begin
            unique case (req.addr)
                bcr_pkg::ADDR_COUNT_LOW:   read_value = select_event_count[7:0];
                bcr_pkg::ADDR_COUNT_HIGH:  read_value = select_event_count[15:8];
                bcr_pkg::ADDR_SUPPLY_MEAS: read_value = supply_meas;
                bcr_pkg::ADDR_TEMP_MEAS:   read_value = temp_meas;
                bcr_pkg::ADDR_HEALTH:      read_value = health_status;
                default:                   read_value = 8'h00;
            endcase
        end
    end

    // A valid write echoes the new content, a read the current one, an erratic access zero.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rsp_valid  <= 1'b0;
            rsp_hit    <= 1'b0;
            rsp_data   <= 8'h00;
            rsp_status <= 8'h00;
        end else begin
            rsp_valid  <= req_valid;
            rsp_hit    <= req_valid && !is_foreign;
            rsp_status <= health_status;
            if (!req_valid || erratic || is_foreign) begin
                rsp_data <= 8'h00;
            end else if (store) begin
                rsp_data <= next_value;
            end else if (req.write && is_health) begin
                rsp_data <= health_status & ~bcr_pkg::HEALTH_ERR_MASK;
            end else begin
                rsp_data <= read_value;
            end
        end
    end

    // Field split of the stored registers; in registers shared by both, the lower field serves output or gate 1.
    always_comb begin
        cfg.gate1_route         = regs[bcr_pkg::IDX_GATE_ROUTE][0];
        cfg.gate2_route         = regs[bcr_pkg::IDX_GATE_ROUTE][1];
        cfg.gate1_phase_route   = regs[bcr_pkg::IDX_GATE_PHASE][0];
        cfg.gate2_phase_route   = regs[bcr_pkg::IDX_GATE_PHASE][1];
        cfg.out1_divider        = regs[bcr_pkg::IDX_OUT1_DIV];
        cfg.out2_divider        = regs[bcr_pkg::IDX_OUT2_DIV];
        cfg.out1_phase_on       = regs[bcr_pkg::IDX_OUT1_PHEN][3:0];
        cfg.out2_phase_on       = regs[bcr_pkg::IDX_OUT2_PHEN][3:0];
        cfg.out1_phase_delay    = regs[bcr_pkg::IDX_OUT1_PHOFF][7:3];
        cfg.out1_phase_off      = regs[bcr_pkg::IDX_OUT1_PHOFF][2:0];
        cfg.out2_phase_delay    = regs[bcr_pkg::IDX_OUT2_PHOFF][7:3];
        cfg.out2_phase_off      = regs[bcr_pkg::IDX_OUT2_PHOFF][2:0];
        cfg.out1_phase_select   = regs[bcr_pkg::IDX_PHASE_SEL][1:0];
        cfg.out2_phase_select   = regs[bcr_pkg::IDX_PHASE_SEL][3:2];
        cfg.out1_prop_gain      = regs[bcr_pkg::IDX_PROP_GAIN][3:0];
        cfg.out2_prop_gain      = regs[bcr_pkg::IDX_PROP_GAIN][7:4];
        cfg.out1_integral_gain  = regs[bcr_pkg::IDX_INTEG_GAIN][3:0];
        cfg.out2_integral_gain  = regs[bcr_pkg::IDX_INTEG_GAIN][7:4];
        cfg.out1_slope_comp     = regs[bcr_pkg::IDX_SLOPE_COMP][3:0];
        cfg.out2_slope_comp     = regs[bcr_pkg::IDX_SLOPE_COMP][7:4];
        cfg.out1_sense_resistor = regs[bcr_pkg::IDX_SENSE_RES][1:0];
        cfg.out2_sense_resistor = regs[bcr_pkg::IDX_SENSE_RES][3:2];
        cfg.gate_supply_level   = regs[bcr_pkg::IDX_GATE_SUPPLY];
        cfg.input_high_limit    = regs[bcr_pkg::IDX_INPUT_HIGH];
        cfg.input_low_limit     = regs[bcr_pkg::IDX_INPUT_LOW];
    end

    // Checks kept beside the logic.

    property p_locked_write_keeps;
        @(posedge clk_sys) disable iff (sys_rst)
        (req_valid && req.write && slot_hit && config_done) |=> $stable(cfg);
    endproperty
    a_locked_write_keeps: assert property (p_locked_write_keeps) else $error("locked write changed config");

    property p_open_write_stores;
        @(posedge clk_sys) disable iff (sys_rst)
        (req_valid && req.write && req.addr == 7'h11 && !config_done)
        |=> (cfg.out1_prop_gain == $past(req.data[3:0])) && (cfg.out2_prop_gain == $past(req.data[7:4]));
    endproperty
    a_open_write_stores: assert property (p_open_write_stores) else $error("open write not stored");

    property p_locked_write_flags;
        @(posedge clk_sys) disable iff (sys_rst)
        (req_valid && req.write && slot_hit && config_done) |=> health_status[bcr_pkg::HB_SERIAL_ERR] && rsp_data == 8'h00;
    endproperty
    a_locked_write_flags: assert property (p_locked_write_flags) else $error("locked write not flagged");

    property p_health_clear;
        @(posedge clk_sys) disable iff (sys_rst)
        (req_valid && req.write && is_health && events == '0 && !frame_len_error) |=> health_err[4:0] == 5'h00;
    endproperty
    a_health_clear: assert property (p_health_clear) else $error("status write did not clear errors");

    property p_health_layout;
        @(posedge clk_sys) disable iff (sys_rst)
        health_status[7:5] == {good1_sync[1], good2_sync[1], gate_sync[1]};
    endproperty
    a_health_layout: assert property (p_health_layout) else $error("good bits misplaced");

    property p_count_high_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (req_valid && !req.write && req.addr == bcr_pkg::ADDR_COUNT_HIGH)
        |=> rsp_valid && rsp_data == $past(select_event_count[15:8]);
    endproperty
    a_count_high_read: assert property (p_count_high_read) else $error("count high byte wrong");

    property p_reset_values;
        @(posedge clk_sys)
        $past(sys_rst) |-> cfg.out1_phase_on == 4'hf && cfg.out2_divider == 8'h0f && cfg.input_high_limit == 8'hff
                           && {cfg.out1_phase_delay, cfg.out1_phase_off} == 8'h39
                           && {cfg.out2_slope_comp, cfg.out1_slope_comp} == 8'h88
                           && {cfg.out2_phase_select, cfg.out1_phase_select} == 4'h4;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

    property p_event_sticky;
        @(posedge clk_sys) disable iff (sys_rst)
        events.overtemp_error ##1 !(req_valid && req.write && is_health) [*3] |=> health_status[bcr_pkg::HB_OVERTEMP];
    endproperty
    a_event_sticky: assert property (p_event_sticky) else $error("overtemp flag lost");

    // Every access gets exactly one answer on the next cycle, so the frame logic never waits.
    property p_answer_next;
        @(posedge clk_sys) disable iff (sys_rst)
        req_valid |=> rsp_valid;
    endproperty
    a_answer_next: assert property (p_answer_next) else $error("answer strobe missing");

    property p_ro_write_flags;
        @(posedge clk_sys) disable iff (sys_rst)
        (req_valid && req.write && is_ro) |=> health_status[bcr_pkg::HB_SERIAL_ERR] && rsp_data == 8'h00;
    endproperty
    a_ro_write_flags: assert property (p_ro_write_flags) else $error("read-only write not flagged");

    // Foreign addresses belong to the control block, so this bank answers them with the hit flag low and zero data.
    property p_foreign_quiet;
        @(posedge clk_sys) disable iff (sys_rst)
        (req_valid && is_foreign) |=> !rsp_hit && rsp_data == 8'h00;
    endproperty
    a_foreign_quiet: assert property (p_foreign_quiet) else $error("foreign address answered");

    property p_count_low_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (req_valid && !req.write && req.addr == bcr_pkg::ADDR_COUNT_LOW)
        |=> rsp_data == $past(select_event_count[7:0]);
    endproperty
    a_count_low_read: assert property (p_count_low_read) else $error("count low byte wrong");

    property p_temp_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (req_valid && !req.write && req.addr == bcr_pkg::ADDR_TEMP_MEAS) |=> rsp_data == $past(temp_meas);
    endproperty
    a_temp_read: assert property (p_temp_read) else $error("temperature read wrong");

    property p_supply_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (req_valid && !req.write && req.addr == bcr_pkg::ADDR_SUPPLY_MEAS) |=> rsp_data == $past(supply_meas);
    endproperty
    a_supply_read: assert property (p_supply_read) else $error("supply read wrong");

    property p_reset_health;
        @(posedge clk_sys)
        $past(sys_rst) |-> health_err == 8'h00;
    endproperty
    a_reset_health: assert property (p_reset_health) else $error("error bits not cleared by reset");

    property p_reset_more;
        @(posedge clk_sys)
        $past(sys_rst) |-> cfg.out2_phase_on == 4'hf && cfg.out1_divider == 8'h0f && cfg.input_low_limit == 8'h00
                           && cfg.out1_prop_gain == 4'h0 && cfg.out2_integral_gain == 4'h0
                           && cfg.out1_sense_resistor == 2'b00 && cfg.out2_sense_resistor == 2'b00;
    endproperty
    a_reset_more: assert property (p_reset_more) else $error("second reset set wrong");

endmodule : bcr_regs

// ---- verif/bcr_master_model.sv ----
// Behavioural model of the microcontroller that issues register accesses through the frame logic.
`timescale 1ns/100ps

module bcr_master_model (
    input  wire logic              clk_sys,   // System clock.
    input  wire logic              sys_rst,   // Synchronous reset, active high.
    input  wire logic              start,     // Bench command: issue one access.
    input  wire bcr_pkg::bcr_req_s cmd,       // Access to issue.
    input  wire logic              rsp_valid, // Answer strobe from the bank.
    input  wire logic              rsp_hit,   // Answer address hit.
    input  wire logic [7:0]        rsp_data,  // Answer data.
    output logic                   req_valid, // Access strobe to the bank.
    output bcr_pkg::bcr_req_s      req,       // Access to the bank.
    output logic                   ans_done,  // Answer captured this cycle.
    output logic                   ans_hit,   // Captured hit flag.
    output logic [7:0]             ans_data   // Captured answer data.
);
    // The bench never lists an internal register for writing, so their defaults stay in place.
    // Outside a request the access word is inverted each cycle, so a stale value is never mistaken for a new one.
    always_ff @(posedge clk_sys) begin
        req_valid <= start & ~sys_rst;
        req       <= start ? cmd : ~req;
    end

    always_ff @(posedge clk_sys) begin
        ans_done <= rsp_valid;
        if (rsp_valid) begin
            ans_hit  <= rsp_hit;
            ans_data <= rsp_data;
        end
    end
endmodule : bcr_master_model

// ---- verif/boost_cfg_diag_regs_tb.sv ----
// Self-checking testbench of the boost register bank.
`timescale 1ns/100ps

module boost_cfg_diag_regs_tb;
    logic              clk_sys;
    logic              sys_rst;
    logic              config_done;
    logic              frame_len_error;
    logic              good1;
    logic              good2;
    logic              good_gate;
    bcr_pkg::bcr_evt_s events;
    logic [15:0]       sel_count;
    logic [7:0]        supply;
    logic [7:0]        temp;
    logic              start;
    bcr_pkg::bcr_req_s cmd;
    logic              req_valid;
    bcr_pkg::bcr_req_s req;
    logic              rsp_valid;
    logic              rsp_hit;
    logic [7:0]        rsp_data;
    logic [7:0]        rsp_status;
    bcr_pkg::bcr_cfg_s cfg;
    logic              ans_done;
    logic              ans_hit;
    logic [7:0]        ans_data;
    int                err_count;
    int                num_checks;

    bcr_regs uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .config_done(config_done), .req_valid(req_valid),
        .req(req), .frame_len_error(frame_len_error), .output1_good(good1), .output2_good(good2),
        .gate_supply_good(good_gate), .events(events), .select_event_count(sel_count), .supply_meas(supply),
        .temp_meas(temp), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_data(rsp_data),
        .rsp_status(rsp_status), .cfg(cfg));

    bcr_master_model master (.clk_sys(clk_sys), .sys_rst(sys_rst), .start(start), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_data(rsp_data), .req_valid(req_valid), .req(req),
        .ans_done(ans_done), .ans_hit(ans_hit), .ans_data(ans_data));

    always #2.5 clk_sys = ~clk_sys;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One access through the master model; the answer lands in ans_hit and ans_data.
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        start <= 1'b1;
        cmd   <= '{write: w, addr: a, data: d};
        @(posedge clk_sys);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (ans_done !== 1'b1 && n < 8);
        if (n >= 8) begin
            err_count++;
            $display("MISMATCH answer wait expected 1 seen 0");
            give_verdict();
        end
    endtask : acc

    task automatic t_reset;
        for (int i = 0; i < bcr_pkg::NUM_REGS; i++) begin
            acc(1'b0, bcr_pkg::REG_ADDR[i], 8'h00);
            chk("reset value", bcr_pkg::REG_RESET[i], ans_data);
        end
        chk("divider reset", 8'h0f, cfg.out1_divider);
        chk("limits reset", 8'hff, cfg.input_high_limit & ~cfg.input_low_limit);
        chk("phase select reset", 8'h04, {4'h0, cfg.out2_phase_select, cfg.out1_phase_select});
        $display("test reset values done");
    endtask : t_reset

    task automatic t_config;
        logic [6:0] a [9] = '{7'h11, 7'h13, 7'h0d, 7'h10, 7'h14, 7'h02, 7'h0b, 7'h0a, 7'h1b};
        logic [7:0] d [9] = '{8'h5a, 8'h3c, 8'hab, 8'hff, 8'hff, 8'h01, 8'h05, 8'h77, 8'h44};
        logic [7:0] e [9] = '{8'h5a, 8'h3c, 8'hab, 8'hef, 8'h0f, 8'h01, 8'h05, 8'h77, 8'h44};
        for (int i = 0; i < 9; i++) begin
            acc(1'b1, a[i], d[i]);
            chk("write echo", e[i], ans_data);
        end
        chk("gains", 8'h5a, {cfg.out2_prop_gain, cfg.out1_prop_gain});
        chk("slope", 8'h3c, {cfg.out2_slope_comp, cfg.out1_slope_comp});
        chk("delay off", 8'hab, {cfg.out1_phase_delay, cfg.out1_phase_off});
        chk("selects", 8'hff, {cfg.out2_phase_select, cfg.out1_phase_select, cfg.out2_sense_resistor,
            cfg.out1_sense_resistor});
        chk("routes", 8'h45, {cfg.gate2_route, cfg.gate1_route, 2'b00, cfg.out1_phase_on});
        chk("divider", 8'h77, cfg.out2_divider);
        chk("low limit", 8'h44, cfg.input_low_limit);
        $display("test configuration writes done");
    endtask : t_config

    task automatic t_lock;
        @(posedge clk_sys);
        config_done <= 1'b1;
        acc(1'b1, 7'h11, 8'h00);
        chk("locked echo", 8'h00, ans_data);
        chk("locked field", 8'h0a, {4'h0, cfg.out1_prop_gain});
        acc(1'b0, 7'h11, 8'h00);
        chk("locked read", 8'h5a, ans_data);
        acc(1'b0, bcr_pkg::ADDR_HEALTH, 8'h00);
        chk("serial flag", 8'ha2, ans_data);
        chk("status copy", 8'ha2, rsp_status);
        acc(1'b1, bcr_pkg::ADDR_HEALTH, 8'hff);
        chk("clear echo", 8'ha0, ans_data);
        acc(1'b0, bcr_pkg::ADDR_HEALTH, 8'h00);
        chk("cleared", 8'ha0, ans_data);
        $display("test locked writes done");
    endtask : t_lock

    task automatic t_diag;
        acc(1'b1, bcr_pkg::ADDR_COUNT_LOW, 8'h55);
        chk("read-only echo", 8'h00, ans_data);
        acc(1'b0, bcr_pkg::ADDR_HEALTH, 8'h00);
        chk("read-only flag", 8'ha2, ans_data);
        acc(1'b1, bcr_pkg::ADDR_HEALTH, 8'h00);
        @(posedge clk_sys);
        events          <= 4'b1001;
        frame_len_error <= 1'b1;
        @(posedge clk_sys);
        events          <= 4'b0000;
        frame_len_error <= 1'b0;
        acc(1'b0, bcr_pkg::ADDR_HEALTH, 8'h00);
        chk("event bits", 8'hb3, ans_data);
        acc(1'b0, bcr_pkg::ADDR_FREQ_TRIM, 8'h00);
        chk("foreign hit", 8'h00, {7'h00, ans_hit});
        $display("test diagnostic bits done");
    endtask : t_diag

    task automatic t_meas;
        @(posedge clk_sys);
        sel_count <= 16'h1234;
        supply    <= 8'h5c;
        temp      <= 8'h7e;
        acc(1'b0, bcr_pkg::ADDR_COUNT_LOW, 8'h00);
        chk("count low", 8'h34, ans_data);
        acc(1'b0, bcr_pkg::ADDR_COUNT_HIGH, 8'h00);
        chk("count high", 8'h12, ans_data);
        acc(1'b0, bcr_pkg::ADDR_SUPPLY_MEAS, 8'h00);
        chk("supply", 8'h5c, ans_data);
        acc(1'b0, bcr_pkg::ADDR_TEMP_MEAS, 8'h00);
        chk("temperature", 8'h7e, ans_data);
        $display("test measurements done");
    endtask : t_meas

    initial begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        config_done = 1'b0;
        frame_len_error = 1'b0;
        good1 = 1'b1;
        good2 = 1'b0;
        good_gate = 1'b1;
        events = 4'b0000;
        sel_count = 16'h0000;
        supply = 8'h00;
        temp = 8'h00;
        start = 1'b0;
        cmd = 16'h0000;
        err_count = 0;
        num_checks = 0;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_config();
        t_lock();
        t_diag();
        t_meas();
        give_verdict();
    end
endmodule : boost_cfg_diag_regs_tb
